// file: chan_mode_asserts.sv
/* Checker for the mode register bank: bus timing, null reads, mode decode.
   Bound to chan_mode_regs from the testbench; sees only its ports. */
`timescale 1ns/1ps
module chan_mode_asserts (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire chan_mode_pkg::line_code_type line_code_a,
  input wire chan_mode_pkg::proto_type proto_a,
  input wire logic [1:0] parity_odd,
  input wire logic [1:0] ctrl_two_octet,
  input wire logic [1:0] code_ascii,
  input wire logic [1:0] addr_compare,
  input wire logic [3:0] addr_fmt
);
  import chan_mode_pkg::*;
  logic [7:0] mode_q;
  logic mapped;
  assign mapped = {1'b0, avs_address[6:2]} inside
    {IDX_MODE_A, IDX_SYNC1_A, IDX_SYNC2_A, IDX_STATUS_A, IDX_CMD_A};
  // shadow of the channel A mode byte, seen from the bus
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      mode_q <= MODE_RESET;
    else if (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == 8'h00)
      mode_q <= avs_writedata[7:0];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_WAIT_ONE: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer late");
  AST_NULL_READ: assert property (avs_read && !avs_waitrequest && !mapped |->
    avs_readdata == {24'h0000, NULL_DATA}) else $error("reserved read not all ones");
  AST_PROTO: assert property (proto_a == proto_type'(mode_q[2:0]))
    else $error("protocol decode wrong");
  AST_ENC: assert property (mode_q[7:6] != 2'b00 |->
    line_code_a == line_code_type'({1'b0, mode_q[7:6]} + 3'd1)) else $error("encoding wrong");
  AST_CTRL: assert property (!mode_q[2] |-> ctrl_two_octet[0] == mode_q[5])
    else $error("control octets wrong");
  AST_PODD: assert property (mode_q[2] && mode_q[1:0] != 2'b01 |->
    parity_odd[0] == mode_q[5]) else $error("parity sense wrong");
  AST_CODE: assert property (mode_q[2:0] == 3'b101 |-> code_ascii[0] == mode_q[5])
    else $error("code set wrong");
  AST_AFMT: assert property (mode_q[2:0] == 3'b001 |-> addr_fmt[1:0] == mode_q[4:3])
    else $error("address format wrong");
  AST_ACMP: assert property (mode_q[2:0] inside {3'b000, 3'b011} |->
    !addr_compare[0]) else $error("address compare on");
  cover property (avs_read && !avs_waitrequest && !mapped);
  cover property (mode_q[2:0] == 3'b010);
  cover property (mode_q[2:0] == 3'b101);
endmodule // chan_mode_asserts

// file: chan_mode_pkg.sv
/*
  Package for the channel mode configuration register bank: register
  indices, field positions, reset values and decoded mode enumerations.
  Assumes one 20 MHz clock and an Avalon-MM slave with byte addressing.
*/
// Overview of operation
// - reads of reserved addresses return all ones, normal cycle.
// - writes to reserved addresses complete but change nothing.
// - unused bits read zero unless software wrote ones since reset (here they always read zero; writes to them are not kept).
// - mode-irrelevant bits stay readable and writable, ignored in current mode.
// - every register reachable as a byte; groups also as 16 or 32 bits (here each register is byte lane 0 of its own word).
// - reset clears a defined subset of control registers to zero.
// - encoding 00 gives NRZ if PLL is NRZI, Manchester if FM.
// - encoding 01 NRZI, 10 FM0, 11 FM1 for both directions.
// - bit-oriented: bit 5 selects one or two octet control field.
// - char/async: bit 5 picks even/odd parity or forced bit value.
// - bisync: bit 5 selects EBCDIC or odd-parity ASCII comparisons.
// - bit-oriented secondary: bits 4:3 select address field format.
// - char/async: bits 4:3 select none, reserved, computed, forced parity.
// - protocol 000 bit-oriented primary, no address compare, all to FIFO.
// - protocol 001 secondary, address compared unless extended addressing.
// - protocol 010 loop mode, transmit echoes receive by two bits.
// - loop go-active-on-poll starts sending on zero then seven ones.
// - loop-sending status bit 6 asserts as loop transmission begins.
// - without go-active-on-poll loop transmitter only echoes received data.
// - protocol 011 loop mode with address comparison disabled.
// - protocol 100 dual-sync, sync on both patterns including parity.
// - protocol 101 bisync dual-sync; software programs 8 bits, no parity.
// - protocol 110 single-sync for external sync, 111 asynchronous.
package chan_mode_pkg;
  localparam int ADDR_W = 8;
  // word indices; byte address is four times the index
  localparam logic [5:0] IDX_MODE_A = 6'h00;
  localparam logic [5:0] IDX_SYNC1_A = 6'h02;
  localparam logic [5:0] IDX_SYNC2_A = 6'h03;
  localparam logic [5:0] IDX_STATUS_A = 6'h19;
  localparam logic [5:0] IDX_CMD_A = 6'h0F;
  localparam logic [5:0] IDX_CHAN_B = 6'h20;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] SYNC_RESET = 8'h00;
  localparam logic [7:0] NULL_DATA = 8'hFF;
  localparam int ENC_HI = 7;
  localparam int ENC_LO = 6;
  localparam int B5_POS = 5;
  localparam int F43_HI = 4;
  localparam int F43_LO = 3;
  localparam int PROT_HI = 2;
  localparam int LOOP_SEND_POS = 6;
  localparam int LOOP_DELAY_BITS = 2;
  localparam int EOP_ONES = 7;
  // command codes written to the command register
  localparam logic [7:0] CMD_GO_ON_LOOP = 8'h01;
  localparam logic [7:0] CMD_GO_OFF_LOOP = 8'h02;
  localparam logic [7:0] CMD_GO_ACTIVE_POLL = 8'h03;
  localparam logic [7:0] CMD_TX_ENABLE = 8'h04;
  localparam logic [7:0] CMD_TX_DISABLE = 8'h05;
  localparam logic [7:0] CMD_PLL_NRZI = 8'h06;
  localparam logic [7:0] CMD_PLL_FM = 8'h07;
  typedef enum logic [2:0] {
    LINE_NRZ, LINE_MANCH, LINE_NRZI, LINE_FM0, LINE_FM1
  } line_code_type;
  typedef enum logic [2:0] {
    PROTO_BOP_PRI, PROTO_BOP_SEC, PROTO_LOOP, PROTO_LOOP_NOADDR,
    PROTO_DUAL_SYNC, PROTO_BISYNC, PROTO_SINGLE_SYNC, PROTO_ASYNC
  } proto_type;
  typedef enum logic [1:0] {
    PAR_NONE, PAR_RESERVED, PAR_COMPUTED, PAR_FORCED
  } parity_type;
  typedef enum logic [1:0] {
    ADR_SINGLE, ADR_EXTENDED, ADR_DUAL, ADR_DUAL_GROUP
  } addr_fmt_type;
endpackage

// file: chan_mode_regs.sv
/*
  Dual-channel mode configuration bank: mode register, sync pattern
  registers, status and command register per channel, mode decode and a
  bit-oriented loop controller with two-bit echo and poll detection.
  Assumes ref_clk at 20 MHz, a line bit clock enable from the bit timing
  logic, and a line receive pin that is asynchronous to ref_clk.
*/
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module chan_mode_regs (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [chan_mode_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] bit_tick,
  input wire logic [1:0] rx_line,
  output logic [1:0] tx_line,
  output logic [1:0] loop_on,
  output chan_mode_pkg::line_code_type line_code_a,
  output chan_mode_pkg::line_code_type line_code_b,
  output chan_mode_pkg::proto_type proto_a,
  output chan_mode_pkg::proto_type proto_b,
  output chan_mode_pkg::parity_type parity_a,
  output chan_mode_pkg::parity_type parity_b,
  output logic [1:0] parity_odd,
  output logic [1:0] ctrl_two_octet,
  output logic [1:0] code_ascii,
  output logic [1:0] addr_compare,
  output logic [3:0] addr_fmt
);
  import chan_mode_pkg::*;

  logic [7:0] mode_q [2];
  logic [7:0] sync1_q [2];
  logic [7:0] sync2_q [2];
  logic [1:0] pll_fm_q;
  logic [1:0] tx_en_q;
  logic [1:0] poll_armed_q;
  logic [1:0] sending_q;
  logic [1:0] loop_q;
  logic [1:0] rx_meta_q;
  logic [1:0] rx_sync_q;
  logic [2:0] echo_q [2];
  logic [7:0] eop_q [2];
  logic ack_q;
  logic [31:0] rdata_q;
  logic [5:0] idx;
  logic chan;
  logic [5:0] loc;
  logic hit;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  line_code_type code_d [2];
  proto_type proto_d [2];

  // one wait state: the answer comes on the second edge of the request
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata = rdata_q;

  // register bytes live at word indices; channel B mirrors at an offset
  assign idx = avs_address[7:2];
  assign chan = (idx >= IDX_CHAN_B);
  assign loc = chan ? idx - IDX_CHAN_B : idx;
  assign wbyte = avs_writedata[7:0];

  always_comb begin
    hit = 1'b1;
    rbyte = NULL_DATA;
    unique case (loc)
      IDX_MODE_A: rbyte = mode_q[chan];
      IDX_SYNC1_A: rbyte = sync1_q[chan];
      IDX_SYNC2_A: rbyte = sync2_q[chan];
      IDX_STATUS_A: begin
        rbyte = STATUS_RESET;
        rbyte[LOOP_SEND_POS] = sending_q[chan];
      end
      IDX_CMD_A: rbyte = 8'h00;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      if (avs_read & ~ack_q) begin
        rdata_q <= {24'h00_0000, rbyte};
      end
    end
  end

  logic wr_go;
  assign wr_go = clk_en & avs_write & ack_q & avs_byteenable[0];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q[0] <= MODE_RESET;
      mode_q[1] <= MODE_RESET;
    end else if (wr_go & hit & (loc == IDX_MODE_A)) begin
      mode_q[chan] <= wbyte;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q[0] <= SYNC_RESET;
      sync1_q[1] <= SYNC_RESET;
      sync2_q[0] <= SYNC_RESET;
      sync2_q[1] <= SYNC_RESET;
    end else if (wr_go & hit) begin
      if (loc == IDX_SYNC1_A) begin
        sync1_q[chan] <= wbyte;
      end
      if (loc == IDX_SYNC2_A) begin
        sync2_q[chan] <= wbyte;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      logic cmd_hit;
      logic is_loop;
      logic eop_seen;
      assign cmd_hit = wr_go & hit & (loc == IDX_CMD_A) & (chan == g);
      assign is_loop = (proto_d[g] == PROTO_LOOP) | (proto_d[g] == PROTO_LOOP_NOADDR);
      // zero then seven ones
      // includes the bit arriving now, so the final one can become the flag zero
      assign eop_seen = ({eop_q[g][6:0], rx_sync_q[g]} == {1'b0, {EOP_ONES{1'b1}}});

      // encoding 00 follows the PLL mode
      always_comb begin
        unique case (mode_q[g][ENC_HI:ENC_LO])
          2'b00: code_d[g] = pll_fm_q[g] ? LINE_MANCH : LINE_NRZ;
          2'b01: code_d[g] = LINE_NRZI;
          2'b10: code_d[g] = LINE_FM0;
          2'b11: code_d[g] = LINE_FM1;
        endcase
      end
      assign proto_d[g] = proto_type'(mode_q[g][PROT_HI:0]);

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          pll_fm_q[g] <= 1'b0;
          tx_en_q[g] <= 1'b0;
          loop_q[g] <= 1'b0;
        end else if (cmd_hit) begin
          if (wbyte == CMD_PLL_FM) pll_fm_q[g] <= 1'b1;
          if (wbyte == CMD_PLL_NRZI) pll_fm_q[g] <= 1'b0;
          if (wbyte == CMD_TX_ENABLE) tx_en_q[g] <= 1'b1;
          if (wbyte == CMD_TX_DISABLE) tx_en_q[g] <= 1'b0;
          if (wbyte == CMD_GO_ON_LOOP) loop_q[g] <= 1'b1;
          if (wbyte == CMD_GO_OFF_LOOP) loop_q[g] <= 1'b0;
        end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          rx_meta_q[g] <= 1'b1;
          rx_sync_q[g] <= 1'b1;
        end else if (clk_en) begin
          rx_meta_q[g] <= rx_line[g];
          rx_sync_q[g] <= rx_meta_q[g];
        end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          echo_q[g] <= 3'b111;
          eop_q[g] <= 8'h00;
        end else if (clk_en & bit_tick[g]) begin
          echo_q[g] <= {echo_q[g][1:0], rx_sync_q[g]};
          eop_q[g] <= {eop_q[g][6:0], rx_sync_q[g]};
        end
      end

      // poll arming, set wins over the clear while sending
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          poll_armed_q[g] <= 1'b0;
          sending_q[g] <= 1'b0;
        end else if (clk_en) begin
          if (cmd_hit & (wbyte == CMD_GO_ACTIVE_POLL)) begin
            poll_armed_q[g] <= 1'b1;
          end else if (sending_q[g]) begin
            poll_armed_q[g] <= 1'b0;
          end
          if (bit_tick[g] & is_loop & loop_q[g] & tx_en_q[g] & poll_armed_q[g]
              & eop_seen) begin
            sending_q[g] <= 1'b1;
          end else if (~is_loop | ~loop_q[g] | ~tx_en_q[g]) begin
            sending_q[g] <= 1'b0;
          end
        end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          tx_line[g] <= 1'b1;
        end else if (clk_en & bit_tick[g]) begin
          // last one turned to zero forming a flag
          if (is_loop & loop_q[g] & ~sending_q[g] & tx_en_q[g] & poll_armed_q[g]
              & eop_seen) begin
            tx_line[g] <= 1'b0;
          end else if (is_loop & loop_q[g] & ~sending_q[g]) begin
            tx_line[g] <= echo_q[g][LOOP_DELAY_BITS-1];
          end else if (~is_loop) begin
            tx_line[g] <= 1'b1;
          end
        end
      end

      assign ctrl_two_octet[g] = mode_q[g][B5_POS] & (proto_d[g] <= PROTO_LOOP_NOADDR);
      assign parity_odd[g] = mode_q[g][B5_POS];
      assign code_ascii[g] = mode_q[g][B5_POS] & (proto_d[g] == PROTO_BISYNC);
      assign addr_fmt[2*g+1:2*g] = mode_q[g][F43_HI:F43_LO];
      assign addr_compare[g] = (proto_d[g] == PROTO_BOP_SEC)
                               & (mode_q[g][F43_HI:F43_LO] != 2'b01);
      assign loop_on[g] = loop_q[g];
    end
  endgenerate

  assign line_code_a = code_d[0];
  assign line_code_b = code_d[1];
  assign proto_a = proto_d[0];
  assign proto_b = proto_d[1];
  assign parity_a = parity_type'(mode_q[0][F43_HI:F43_LO]);
  assign parity_b = parity_type'(mode_q[1][F43_HI:F43_LO]);

endmodule // chan_mode_regs

// file: host_bus_model.sv
/* Host processor model: Avalon-MM master doing single byte transfers.
   Assumes the slave answers by dropping waitrequest on ref_clk. */
`timescale 1ns/1ps
module host_bus_model (
  input wire logic ref_clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
  end
  // request held until waitrequest is seen low
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic [3:0] be, output logic [7:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0000, d};
    avs_byteenable <= be;
    @(posedge ref_clk iff avs_waitrequest === 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge ref_clk);
  endtask
endmodule // host_bus_model

// file: serial_channel_mode_config_tb.sv
/* Testbench for chan_mode_regs: register model, null map, decode, loop.
   Assumes host_bus_model and the checker are compiled alongside. */
`timescale 1ns/1ps
module serial_channel_mode_config_tb;
  import chan_mode_pkg::*;
  logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [1:0] bit_tick, rx_line, tx_line, loop_on, parity_odd, ctrl_two_octet, code_ascii;
  logic [1:0] addr_compare;
  logic [3:0] addr_fmt, avs_byteenable;
  logic [7:0] avs_address, q, d;
  logic [31:0] avs_writedata, avs_readdata;
  line_code_type line_code_a, line_code_b;
  proto_type proto_a, proto_b;
  parity_type parity_a, parity_b;
  int n_mismatch, check_count, seed, k;
  logic [7:0] model [int];
  logic [7:0] rw [6] = '{8'h00, 8'h08, 8'h0C, 8'h80, 8'h88, 8'h8C};
  logic [7:0] nul [4] = '{8'h04, 8'h74, 8'hFC, 8'hA0};
  chan_mode_regs i_chan_mode_regs (.ref_clk, .rst_n, .clk_en(1'b1), .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .bit_tick,
    .rx_line, .tx_line, .loop_on, .line_code_a, .line_code_b, .proto_a, .proto_b, .parity_a,
    .parity_b, .parity_odd, .ctrl_two_octet, .code_ascii, .addr_compare, .addr_fmt);
  host_bus_model i_host_bus_model (.ref_clk, .avs_waitrequest, .avs_readdata, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] be = 4'hF);
    i_host_bus_model.xfer(1'b1, a, v, be, q);
    if (model.exists(a) && be[0])
      model[a] = v;
  endtask
  task automatic rd_chk(input logic [7:0] a);
    i_host_bus_model.xfer(1'b0, a, 8'h00, 4'hF, q);
    check(q, model.exists(a) ? model[a] : NULL_DATA);
  endtask
  task automatic do_reset;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rw[i]) model[rw[i]] = rw[i][3] ? SYNC_RESET : MODE_RESET;
  endtask
  task automatic send_eop;
    for (int i = 0; i < 8; i++) begin
      rx_line[0] <= (i != 0);
      repeat (3) @(posedge ref_clk);
      bit_tick[0] <= 1'b1;
      @(posedge ref_clk);
      bit_tick[0] <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    i_host_bus_model.xfer(1'b0, 8'h64, 8'h00, 4'hF, q);
  endtask
  initial begin
    seed = 32'h885f;
    rst_n = 1'b0;
    bit_tick = 2'b00;
    rx_line = 2'b11;
    do_reset();
    foreach (rw[i]) rd_chk(rw[i]);
    foreach (nul[i]) begin
      wr(nul[i], 8'h5A);
      rd_chk(nul[i]);
    end
    foreach (rw[i]) rd_chk(rw[i]);
    repeat (40) begin
      d = $random(seed);
      k = $unsigned($random(seed)) % 6;
      if (d[2:0] == 3'b101)
        d[4:3] = 2'b00;
      wr(rw[k], d);
      rd_chk(rw[k]);
      check(proto_b, proto_type'(model[8'h80][2:0]));
      if (model[8'h80][7:6] != 2'b00)
        check(line_code_b, line_code_type'({1'b0, model[8'h80][7:6]} + 3'd1));
    end
    wr(8'h00, 8'hA5, 4'b1110);
    rd_chk(8'h00);
    wr(8'h00, 8'h00);
    wr(8'h3C, CMD_PLL_FM);
    check(line_code_a, LINE_MANCH);
    wr(8'h3C, CMD_PLL_NRZI);
    check(line_code_a, LINE_NRZ);
    // mode set while transmitter is off
    wr(8'h00, 8'h02);
    wr(8'h3C, CMD_GO_ON_LOOP);
    check(loop_on[0], 1'b1);
    send_eop();
    check(q[LOOP_SEND_POS], 1'b0);
    check(tx_line[0], 1'b1);
    wr(8'h3C, CMD_TX_ENABLE);
    wr(8'h3C, CMD_GO_ACTIVE_POLL);
    send_eop();
    check(q[LOOP_SEND_POS], 1'b1);
    check(tx_line[0], 1'b0);
    wr(8'h3C, CMD_GO_OFF_LOOP);
    check(loop_on[0], 1'b0);
    do_reset();
    rd_chk(8'h00);
    rd_chk(8'h80);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    wrap_up();
  end
endmodule // serial_channel_mode_config_tb
bind chan_mode_regs chan_mode_asserts i_chan_mode_asserts (.ref_clk, .rst_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .line_code_a, .proto_a, .parity_odd, .ctrl_two_octet, .code_ascii, .addr_compare, .addr_fmt);
